// file: verilog/epi_pkg.sv
// Package of constants and types for the external pin interrupt block
package epi_pkg;

	// Register bus widths
	localparam int unsigned EPI_AW = 8; // Register address width
	localparam int unsigned EPI_DW = 8; // Register data width

	// Pin counts
	localparam int unsigned EPI_PC_N = 12; // All pin-change inputs
	localparam int unsigned EPI_PC_LO_N = 8; // Group 0 inputs 7:0
	localparam int unsigned EPI_PC_HI_N = 4; // Group 1 inputs 11:8

	// Register offsets
	localparam logic [EPI_AW-1:0] EPI_OFS_PC_MASK_LOW = 8'h0f;
	localparam logic [EPI_AW-1:0] EPI_OFS_PC_MASK_HIGH = 8'h10;
	localparam logic [EPI_AW-1:0] EPI_OFS_PC_FLAGS = 8'h11;
	localparam logic [EPI_AW-1:0] EPI_OFS_PC_ENABLES = 8'h12;
	localparam logic [EPI_AW-1:0] EPI_OFS_EXT_ENABLE = 8'h13;
	localparam logic [EPI_AW-1:0] EPI_OFS_EXT_FLAGS = 8'h14;
	localparam logic [EPI_AW-1:0] EPI_OFS_EXT_SENSE = 8'h15;

	// Reset values
	localparam logic [EPI_DW-1:0] EPI_RST_REG = 8'h00; // Every register
	localparam logic [EPI_DW-1:0] EPI_RDATA_IDLE = 8'h00; // Read data outside answer

	// Field positions
	localparam int unsigned EPI_BIT_EXT0 = 0; // Ext pin enable and flag bit
	localparam int unsigned EPI_BIT_GRP0 = 0; // Group 0 enable and flag bit
	localparam int unsigned EPI_BIT_GRP1 = 1; // Group 1 enable and flag bit
	localparam int unsigned EPI_SENSE_LSB = 0; // Sense select field low bit
	localparam int unsigned EPI_SENSE_W = 2; // Sense select field width

	// Sense select codes of the dedicated pin
	typedef enum logic [1:0] {
		EPI_SENSE_LOW = 2'h0, // Low level
		EPI_SENSE_ANY = 2'h1, // Any logical change
		EPI_SENSE_FALL = 2'h2, // Falling edge
		EPI_SENSE_RISE = 2'h3 // Rising edge
	} epi_sense_e;

	// Register bus request from software
	typedef struct packed {
		logic [EPI_AW-1:0] addr; // Register address
		logic [EPI_DW-1:0] wdata; // Write data
		logic wr; // Write strobe
		logic rd; // Read strobe
	} epi_bus_req_s;

	// Interrupt requests toward the dispatch, one per vector
	typedef struct packed {
		logic pc_group1; // Pin-change group 1 vector
		logic pc_group0; // Pin-change group 0 vector
		logic ext0; // Dedicated pin vector
	} epi_irq_s;

endpackage : epi_pkg

// file: verilog/epi_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module epi_sync #(
	parameter int unsigned W = 1 // Number of pins
) (
	input wire logic sys_clk_i, // I/O clock
	input wire logic rst_i, // Asynchronous reset, active high
	input wire logic [W-1:0] pin_i, // Raw pins from outside the domain
	output logic [W-1:0] third_o, // Third stage, every sampled level
	output logic [W-1:0] stable_o // Level once stages two and three agree
);

	logic [W-1:0] s1_q; // First stage, read only by the second
	logic [W-1:0] s2_q; // Second stage
	logic [W-1:0] s3_q; // Third stage
	logic [W-1:0] stable_q; // Filtered level
	logic [W-1:0] stable_d; // Next filtered level

	// Take a new level only where two and three agree
	always_comb
	begin
		stable_d = stable_q;
		for (int i = 0; i < W; i++)
		begin
			if (s2_q[i] == s3_q[i])
			begin
				stable_d[i] = s3_q[i];
			end
		end
	end

	// Stage registers
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			stable_q <= '0;
		end
		else
		begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stable_q <= stable_d;
		end
	end

	assign third_o = s3_q;
	assign stable_o = stable_q;

endmodule : epi_sync

`default_nettype wire

// file: verilog/epi_top.sv
// External pin and pin-change interrupt controller with register port
// Summary of operation
// - Interrupts still fire with pins driven as outputs
// - Pin-change detection works without the clock
// - Level mode requests while pin stays low
// - Dedicated pin edges need the I/O clock
// - Low level detected asynchronously for wake
// - Level gone before wake gives no interrupt
// - Sense code: low, change, fall, rise
// - Sample pin first; pulses over one clock caught
// - Dedicated request needs enable and global enable
// - Edge sets flag; service or one clears
// - Dedicated flag held clear in level mode
// - Group 1 requests need enable and global enable
// - Group 0 requests need enable and global enable
// - Change on inputs 11:8 sets group 1 flag
// - Change on inputs 7:0 sets group 0 flag
// - Low mask bits select inputs 7:0
// - High mask bits select inputs 11:8
`timescale 1ns/1ps
`default_nettype none

module epi_top
	import epi_pkg::*;
(
	input wire logic sys_clk_i, // I/O clock, 10 MHz
	input wire logic rst_i, // Asynchronous reset, active high
	input wire logic [EPI_AW-1:0] addr_i, // Register address
	input wire logic [EPI_DW-1:0] wdata_i, // Register write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [EPI_DW-1:0] rdata_o, // Read data, cycle after read strobe
	input wire logic ext_irq0_pin_i, // Dedicated interrupt pin level
	input wire logic [EPI_PC_N-1:0] pin_change_input_i, // Pin-change pin levels
	input wire logic global_irq_enable_i, // Global enable bit of the core
	input wire logic [2:0] irq_ack_i, // Vector taken: {group1, group0, ext0}
	output epi_irq_s irq_req_o, // Per-vector requests
	output logic irq_o, // Any unmasked pending request
	output logic wake_o // Asynchronous wake request
);

	// Bus request bundle
	epi_bus_req_s bus;
	// Software registers and their next values
	logic [EPI_PC_LO_N-1:0] mask_low_q, mask_low_d; // Group 0 mask
	logic [EPI_PC_HI_N-1:0] mask_high_q, mask_high_d; // Group 1 mask
	logic [1:0] grp_en_q, grp_en_d; // Group enables
	logic ext_en_q, ext_en_d; // Dedicated pin enable
	epi_sense_e sense_q, sense_d; // Dedicated pin sense select
	// Sticky flags, set by events and cleared by software or service
	logic [1:0] grp_flag_q, grp_flag_d; // Group flags
	logic ext_flag_q, ext_flag_d; // Dedicated pin flag
	// Read data register
	logic [EPI_DW-1:0] rdata_q, rdata_d;
	// Synchronised pin levels
	logic [EPI_PC_N-1:0] pc_stable; // Filtered pin-change levels
	logic [EPI_PC_N-1:0] pc_prev_q; // Filtered levels one cycle back
	logic ext_third; // Dedicated pin, third stage
	logic ext_stable; // Dedicated pin, filtered
	logic ext_prev_q; // Third stage one cycle back
	// Detected events
	logic ext_rise, ext_fall; // Edges seen on the sampled pin
	logic ext_edge_hit; // Edge matching the sense select
	logic level_mode; // Dedicated pin in level mode
	logic [EPI_PC_N-1:0] pc_change; // Changed and unmasked pins
	logic grp0_hit, grp1_hit; // Group events
	// Write decode helpers
	logic wr_ext_flags, wr_pc_flags;

	// True when a write strobe hits one offset
	function automatic logic wr_hit(input epi_bus_req_s b, input logic [EPI_AW-1:0] ofs);
		wr_hit = b.wr && (b.addr == ofs);
	endfunction : wr_hit
	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	// Both pin groups pass the same filtered synchroniser
	epi_sync #(.W(EPI_PC_N)) u_pc_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.pin_i(pin_change_input_i), // Pin level read even when driven
		.third_o(),
		.stable_o(pc_stable) // Flags see only filtered levels
	);
	// Dedicated pin sampled before edge detection
	epi_sync #(.W(1)) u_ext_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.pin_i(ext_irq0_pin_i), // Pin level read even when driven
		.third_o(ext_third),
		.stable_o(ext_stable)
	);

	// Edge detection on the third stage, so one-sample pulses still count
	always_comb
	begin
		level_mode = (sense_q == EPI_SENSE_LOW);
		ext_rise = ext_third && !ext_prev_q; // Clocked edge only
		ext_fall = !ext_third && ext_prev_q; // Clocked edge only
		case (sense_q) // Sense code decode
			EPI_SENSE_ANY: ext_edge_hit = ext_rise || ext_fall;
			EPI_SENSE_FALL: ext_edge_hit = ext_fall;
			EPI_SENSE_RISE: ext_edge_hit = ext_rise;
			default: ext_edge_hit = 1'b0;
		endcase
	end

	// Changes on filtered pins, gated by the mask bits
	always_comb
	begin
		pc_change = (pc_stable ^ pc_prev_q) & {mask_high_q, mask_low_q};
		grp0_hit = |pc_change[EPI_PC_LO_N-1:0];
		grp1_hit = |pc_change[EPI_PC_N-1:EPI_PC_LO_N];
	end

	// Write decode for the two flag registers
	assign wr_ext_flags = wr_hit(bus, EPI_OFS_EXT_FLAGS);
	assign wr_pc_flags = wr_hit(bus, EPI_OFS_PC_FLAGS);

	// Control register writes
	always_comb
	begin
		mask_low_d = mask_low_q;
		mask_high_d = mask_high_q;
		grp_en_d = grp_en_q;
		ext_en_d = ext_en_q;
		sense_d = sense_q;
		if (wr_hit(bus, EPI_OFS_PC_MASK_LOW))
		begin
			mask_low_d = bus.wdata;
		end
		if (wr_hit(bus, EPI_OFS_PC_MASK_HIGH))
		begin
			mask_high_d = bus.wdata[EPI_PC_HI_N-1:0];
		end
		if (wr_hit(bus, EPI_OFS_PC_ENABLES))
		begin
			grp_en_d = {bus.wdata[EPI_BIT_GRP1], bus.wdata[EPI_BIT_GRP0]};
		end
		if (wr_hit(bus, EPI_OFS_EXT_ENABLE))
		begin
			ext_en_d = bus.wdata[EPI_BIT_EXT0];
		end
		if (wr_hit(bus, EPI_OFS_EXT_SENSE))
		begin
			sense_d = epi_sense_e'(bus.wdata[EPI_SENSE_LSB +: EPI_SENSE_W]);
		end
	end

	// Sticky flags: write one or vector taken clears, a new event wins
	always_comb
	begin
		ext_flag_d = ext_flag_q;
		grp_flag_d = grp_flag_q;
		if ((wr_ext_flags && bus.wdata[EPI_BIT_EXT0]) || irq_ack_i[0])
		begin
			ext_flag_d = 1'b0;
		end
		if (ext_edge_hit)
		begin
			ext_flag_d = 1'b1;
		end
		if (level_mode)
		begin
			ext_flag_d = 1'b0; // Never set while level sensing
		end
		if ((wr_pc_flags && bus.wdata[EPI_BIT_GRP0]) || irq_ack_i[1])
		begin
			grp_flag_d[0] = 1'b0;
		end
		if ((wr_pc_flags && bus.wdata[EPI_BIT_GRP1]) || irq_ack_i[2])
		begin
			grp_flag_d[1] = 1'b0;
		end
		if (grp0_hit)
		begin
			grp_flag_d[0] = 1'b1;
		end
		if (grp1_hit)
		begin
			grp_flag_d[1] = 1'b1;
		end
	end

	// Read mux; data stand only in the cycle after the strobe
	always_comb
	begin
		rdata_d = EPI_RDATA_IDLE;
		if (bus.rd)
		begin
			case (bus.addr)
				EPI_OFS_PC_MASK_LOW: rdata_d = mask_low_q;
				EPI_OFS_PC_MASK_HIGH: rdata_d = {{(EPI_DW-EPI_PC_HI_N){1'b0}}, mask_high_q};
				EPI_OFS_PC_FLAGS: rdata_d = {6'h00, grp_flag_q};
				EPI_OFS_PC_ENABLES: rdata_d = {6'h00, grp_en_q};
				EPI_OFS_EXT_ENABLE: rdata_d = {7'h00, ext_en_q};
				EPI_OFS_EXT_FLAGS: rdata_d = {7'h00, ext_flag_q};
				EPI_OFS_EXT_SENSE: rdata_d = {6'h00, sense_q};
				default: rdata_d = EPI_RDATA_IDLE; // Unmapped reads as zero
			endcase
		end
	end

	// All state registers
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mask_low_q <= EPI_RST_REG;
			mask_high_q <= EPI_RST_REG[EPI_PC_HI_N-1:0];
			grp_en_q <= EPI_RST_REG[1:0];
			ext_en_q <= EPI_RST_REG[EPI_BIT_EXT0];
			sense_q <= EPI_SENSE_LOW;
			grp_flag_q <= EPI_RST_REG[1:0];
			ext_flag_q <= EPI_RST_REG[EPI_BIT_EXT0];
			rdata_q <= EPI_RDATA_IDLE;
			pc_prev_q <= '0;
			ext_prev_q <= 1'b0;
		end
		else
		begin
			mask_low_q <= mask_low_d;
			mask_high_q <= mask_high_d;
			grp_en_q <= grp_en_d;
			ext_en_q <= ext_en_d;
			sense_q <= sense_d;
			grp_flag_q <= grp_flag_d;
			ext_flag_q <= ext_flag_d;
			rdata_q <= rdata_d;
			pc_prev_q <= pc_stable;
			ext_prev_q <= ext_third;
		end
	end

	// Requests toward the dispatch; flags and enables act as status and mask
	always_comb
	begin
		// Level request lasts only while the filtered pin is low
		irq_req_o.ext0 = global_irq_enable_i && ext_en_q
			&& (level_mode ? !ext_stable : ext_flag_q);
		irq_req_o.pc_group0 = global_irq_enable_i && grp_en_q[0] && grp_flag_q[0];
		irq_req_o.pc_group1 = global_irq_enable_i && grp_en_q[1] && grp_flag_q[1];
		irq_o = |irq_req_o;
	end

	// Wake path from raw pins, no clock needed while asleep
	always_comb
	begin
		wake_o = (ext_en_q && level_mode && !ext_irq0_pin_i)
			|| (grp_en_q[0] && |((pin_change_input_i[EPI_PC_LO_N-1:0]
			^ pc_stable[EPI_PC_LO_N-1:0]) & mask_low_q))
			|| (grp_en_q[1] && |((pin_change_input_i[EPI_PC_N-1:EPI_PC_LO_N]
			^ pc_stable[EPI_PC_N-1:EPI_PC_LO_N]) & mask_high_q));
	end

	assign rdata_o = rdata_q;

	// Flag stays clear one cycle after level mode is seen
	property p_level_flag_clear;
		@(posedge sys_clk_i) disable iff (rst_i)
		level_mode |=> !ext_flag_q;
	endproperty
	a_level_flag_clear: assert property (p_level_flag_clear)
		else $error("Dedicated flag set in level mode");
	// Low filtered pin in level mode gives a request at once
	property p_level_req;
		@(posedge sys_clk_i) disable iff (rst_i)
		(level_mode && ext_en_q && global_irq_enable_i && !ext_stable) |-> irq_req_o.ext0;
	endproperty
	a_level_req: assert property (p_level_req)
		else $error("Level request missing while pin low");
	// No request of any vector without the global enable
	property p_no_req_without_global;
		@(posedge sys_clk_i) disable iff (rst_i)
		!global_irq_enable_i |-> !irq_o;
	endproperty
	a_no_req_without_global: assert property (p_no_req_without_global)
		else $error("Request raised with global enable clear");
	// Falling edge in fall mode sets the flag on the next edge
	property p_fall_sets_flag;
		@(posedge sys_clk_i) disable iff (rst_i)
		(sense_q == EPI_SENSE_FALL && ext_prev_q && !ext_third) |=> ext_flag_q;
	endproperty
	a_fall_sets_flag: assert property (p_fall_sets_flag)
		else $error("Falling edge did not set flag");
	// Rising edge in fall mode leaves a clear flag clear
	property p_rise_ignored_in_fall;
		@(posedge sys_clk_i) disable iff (rst_i)
		(sense_q == EPI_SENSE_FALL && !ext_prev_q && ext_third && !ext_flag_q) |=> !ext_flag_q;
	endproperty
	a_rise_ignored_in_fall: assert property (p_rise_ignored_in_fall)
		else $error("Rising edge set flag in fall mode");
	// A raw pin pulse held two clocks reaches the flag within six
	property p_pulse_caught;
		@(posedge sys_clk_i) disable iff (rst_i)
		(sense_q == EPI_SENSE_ANY && $rose(ext_irq0_pin_i)) ##1 ext_irq0_pin_i
			##0 (sense_q == EPI_SENSE_ANY)[*4] |-> ##[0:2] ext_flag_q;
	endproperty
	a_pulse_caught: assert property (p_pulse_caught)
		else $error("Long pulse on dedicated pin missed");
	// Masked change in group 0 sets its flag
	property p_grp0_set;
		@(posedge sys_clk_i) disable iff (rst_i)
		|((pc_stable[EPI_PC_LO_N-1:0] ^ pc_prev_q[EPI_PC_LO_N-1:0]) & mask_low_q)
			|=> grp_flag_q[0];
	endproperty
	a_grp0_set: assert property (p_grp0_set)
		else $error("Group 0 change did not set flag");
	// Masked change in group 1 sets its flag
	property p_grp1_set;
		@(posedge sys_clk_i) disable iff (rst_i)
		|((pc_stable[EPI_PC_N-1:EPI_PC_LO_N] ^ pc_prev_q[EPI_PC_N-1:EPI_PC_LO_N])
			& mask_high_q) |=> grp_flag_q[1];
	endproperty
	a_grp1_set: assert property (p_grp1_set)
		else $error("Group 1 change did not set flag");
	// With every group 0 mask bit clear, a clear group 0 flag stays clear
	property p_grp0_masked;
		@(posedge sys_clk_i) disable iff (rst_i)
		(mask_low_q == '0 && !grp_flag_q[0]) |=> !grp_flag_q[0];
	endproperty
	a_grp0_masked: assert property (p_grp0_masked)
		else $error("Masked group 0 pins set flag");
	// Group 1 request follows enable and flag
	property p_grp1_req;
		@(posedge sys_clk_i) disable iff (rst_i)
		irq_req_o.pc_group1 |-> (grp_en_q[1] && grp_flag_q[1] && global_irq_enable_i);
	endproperty
	a_grp1_req: assert property (p_grp1_req)
		else $error("Group 1 request without cause");
	// Group 0 request appears with enable and flag
	property p_grp0_req;
		@(posedge sys_clk_i) disable iff (rst_i)
		(grp_en_q[0] && grp_flag_q[0] && global_irq_enable_i) |-> irq_req_o.pc_group0;
	endproperty
	a_grp0_req: assert property (p_grp0_req)
		else $error("Group 0 request missing");

	// Write one to the dedicated flag clears it without a new edge
	property p_w1c_ext;
		@(posedge sys_clk_i) disable iff (rst_i)
		(wr_ext_flags && wdata_i[EPI_BIT_EXT0] && !ext_edge_hit) |=> !ext_flag_q;
	endproperty
	a_w1c_ext: assert property (p_w1c_ext)
		else $error("Write one did not clear flag");

	// Raw low pin in level mode wakes with no clock edge needed
	property p_wake_level;
		@(posedge sys_clk_i) disable iff (rst_i)
		(ext_en_q && level_mode && !ext_irq0_pin_i) |-> wake_o;
	endproperty
	a_wake_level: assert property (p_wake_level)
		else $error("Wake missing on low level");

	// Unread cycles show zero read data
	property p_rdata_idle;
		@(posedge sys_clk_i) disable iff (rst_i)
		!rd_i |=> (rdata_o == EPI_RDATA_IDLE);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("Read data outside answer cycle");

endmodule : epi_top

`default_nettype wire

// file: verif/epi_partner.sv
// Model of the core's interrupt dispatch that services pending vectors
`timescale 1ns/1ps
`default_nettype none

module epi_partner
	import epi_pkg::*;
(
	input wire logic sys_clk_i, // I/O clock
	input wire logic rst_i, // Asynchronous reset, active high
	input wire epi_irq_s irq_req_i, // Requests from the block
	input wire logic serve_i, // Dispatch may take vectors
	output logic [2:0] irq_ack_o, // One-cycle vector taken pulse
	output logic [2:0][7:0] served_o // Vectors taken so far
);
	logic [2:0] req; // Requests as plain bits, ext0 lowest
	logic [2:0] pick; // Lowest vector number pending
	logic [1:0] busy_q; // Routine still running after a take
	assign req = irq_req_i;
	assign pick = req & (~req + 3'h1);

	// Take one vector, then stay busy so a stale request is not taken twice
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			irq_ack_o <= 3'h0;
			busy_q <= 2'h0;
			served_o <= '0;
		end
		else if (busy_q != 2'h0)
		begin
			// Ack is a single cycle
			irq_ack_o <= 3'h0;
			busy_q <= busy_q - 2'h1;
		end
		else if (serve_i && (req != 3'h0))
		begin
			irq_ack_o <= pick;
			busy_q <= 2'h3;
			for (int v = 0; v < 3; v++)
			begin
				if (pick[v])
					served_o[v] <= served_o[v] + 8'h01;
			end
		end
	end
endmodule : epi_partner
`default_nettype wire

// file: verif/epi_top_tb.sv
// Self-checking bench for the external pin interrupt block
`timescale 1ns/1ps
`default_nettype none

module epi_top_tb
	import epi_pkg::*;
;
	logic clk, rst, wr, rd, pin0, gie, serve, irq, wake; // Bench-driven and observed bits
	logic [7:0] addr, wdata, rdata; // Register port
	logic [11:0] pc; // Pin-change pins
	logic [2:0] ack; // Vector taken from the dispatch model
	logic [2:0][7:0] served; // Service counts per vector
	epi_irq_s req; // Per-vector requests
	int fails, n_checks; // Verdict counters
	int seed = 32'h7009; // Fixed random seed
	logic [7:0] expq [$]; // Expected read data, oldest first
	logic rd_pend = 1'b0; // Read answer due this cycle
	localparam logic [7:0] RW_A [5] = '{8'h0f, 8'h10, 8'h12, 8'h13, 8'h15}; // RW places
	localparam logic [7:0] RW_M [5] = '{8'hff, 8'h0f, 8'h03, 8'h01, 8'h03}; // Their live bits

	epi_top i_dut (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .ext_irq0_pin_i(pin0), .pin_change_input_i(pc),
		.global_irq_enable_i(gie), .irq_ack_i(ack), .irq_req_o(req), .irq_o(irq),
		.wake_o(wake));
	epi_partner i_core (.sys_clk_i(clk), .rst_i(rst), .irq_req_i(req), .serve_i(serve),
		.irq_ack_o(ack), .served_o(served));

	// Free-running 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Compare one value, count it, report a miss
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk

	// Single place where the run ends
	task automatic give_verdict();
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// One-cycle read strobe; the answer is judged by the monitor
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		expq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg

	// Read data only stand the cycle after the strobe, so judge it there
	always @(posedge clk)
	begin
		if (rd_pend)
			chk(rdata, expq.pop_front());
		rd_pend = rd;
	end

	// Hang guard, far beyond the several hundred cycles the run needs
	initial
	begin
		#(100 * 20000);
		fails++;
		give_verdict();
	end

	// Main sequence
	initial
	begin
		logic [7:0] d; // Random write value
		logic g, e, hi; // Random global enable, expected flag, upper group
		int j; // Neighbour pin left masked
		rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		pin0 = 1'b1;
		pc = 12'hfff;
		gie = 1'b0;
		serve = 1'b0;
		tick(12);
		rst <= 1'b0;
		// Let the synchronisers catch up with idle-high pins before any mask
		tick(10);
		for (int i = 0; i < 7; i++)
			rd_reg(EPI_OFS_PC_MASK_LOW + 8'(i), EPI_RST_REG);
		wr_reg(8'h20, 8'hff);
		rd_reg(8'h20, 8'h00);
		rd_reg(8'h0e, 8'h00);
		chk(irq, 1'b0);
		chk(wake, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			d = 8'($random(seed));
			wr_reg(RW_A[i], d);
			rd_reg(RW_A[i], d & RW_M[i]);
			wr_reg(RW_A[i], 8'h00);
		end
		// Edge codes: a lone fall, a lone rise, then a two-cycle low pulse
		wr_reg(EPI_OFS_EXT_ENABLE, 8'h01);
		for (int c = 1; c < 4; c++)
		begin
			wr_reg(EPI_OFS_EXT_SENSE, 8'(c));
			for (int s = 0; s < 3; s++)
			begin
				g = 1'($random(seed));
				e = (s == 0) ? (c != 3) : ((s == 1) ? (c != 2) : 1'b1);
				@(posedge clk);
				gie <= g;
				pin0 <= (s == 1);
				if (s == 2)
				begin
					tick(2);
					pin0 <= 1'b1;
				end
				tick(8);
				#1;
				chk(req.ext0, e & g);
				chk(irq, e & g);
				rd_reg(EPI_OFS_EXT_FLAGS, {7'h0, e});
				wr_reg(EPI_OFS_EXT_FLAGS, 8'h01);
			end
		end
		// Rise still selected; clear this one by service instead
		@(posedge clk);
		gie <= 1'b1;
		pin0 <= 1'b0;
		tick(3);
		pin0 <= 1'b1;
		tick(8);
		serve <= 1'b1;
		tick(6);
		serve <= 1'b0;
		rd_reg(EPI_OFS_EXT_FLAGS, 8'h00);
		chk(served[0], 8'h01);
		// Level mode: request while held low, no flag ever
		wr_reg(EPI_OFS_EXT_SENSE, 8'h00);
		@(posedge clk);
		pin0 <= 1'b0; // Held low through many services
		@(posedge clk);
		#1;
		chk(wake, 1'b1);
		tick(6);
		#1;
		chk(req.ext0, 1'b1);
		rd_reg(EPI_OFS_EXT_FLAGS, 8'h00);
		@(posedge clk);
		serve <= 1'b1;
		tick(20);
		serve <= 1'b0;
		chk(served[0] >= 8'h03, 1'b1);
		pin0 <= 1'b1; // Level gone, nothing left pending
		tick(6);
		#1;
		chk(req.ext0, 1'b0);
		chk(wake, 1'b0);
		wr_reg(EPI_OFS_EXT_ENABLE, 8'h00);
		// Each pin-change input alone, with a masked neighbour toggling first
		wr_reg(EPI_OFS_PC_ENABLES, 8'h03);
		for (int i = 0; i < 12; i++)
		begin
			j = (i + 1) % 12;
			hi = (i >= 8);
			wr_reg(hi ? EPI_OFS_PC_MASK_LOW : EPI_OFS_PC_MASK_HIGH, 8'h00);
			wr_reg(hi ? EPI_OFS_PC_MASK_HIGH : EPI_OFS_PC_MASK_LOW, 8'(1 << (i % 8)));
			@(posedge clk);
			pc[j] <= ~pc[j];
			tick(8);
			rd_reg(EPI_OFS_PC_FLAGS, 8'h00);
			@(posedge clk);
			pc[i] <= ~pc[i];
			@(posedge clk);
			#1;
			chk(wake, 1'b1);
			tick(8);
			#1;
			chk(hi ? req.pc_group1 : req.pc_group0, 1'b1);
			rd_reg(EPI_OFS_PC_FLAGS, hi ? 8'h02 : 8'h01);
			if (i % 2 == 1)
			begin
				@(posedge clk);
				serve <= 1'b1;
				tick(6);
				serve <= 1'b0;
			end
			else
				wr_reg(EPI_OFS_PC_FLAGS, hi ? 8'h02 : 8'h01);
			rd_reg(EPI_OFS_PC_FLAGS, 8'h00);
		end
		chk(served[1], 8'h04);
		chk(served[2], 8'h02);
		// Global enable gates the request, checked with the group enable clear and then set
		for (int k = 0; k < 2; k++)
		begin
			wr_reg(EPI_OFS_PC_MASK_LOW, 8'(k == 0));
			wr_reg(EPI_OFS_PC_MASK_HIGH, 8'(k == 1));
			wr_reg(EPI_OFS_PC_ENABLES, 8'h00);
			@(posedge clk);
			gie <= 1'b0;
			pc[8 * k] <= ~pc[8 * k];
			tick(8);
			#1;
			chk(irq, 1'b0);
			wr_reg(EPI_OFS_PC_ENABLES, 8'(1 << k));
			#1;
			chk(irq, 1'b0);
			// Global enable changes on a rising edge like every other input
			@(posedge clk);
			gie <= 1'b1;
			@(posedge clk);
			#1;
			chk(k ? req.pc_group1 : req.pc_group0, 1'b1);
			wr_reg(EPI_OFS_PC_FLAGS, 8'h03);
		end
		tick(3);
		give_verdict();
	end
endmodule : epi_top_tb
`default_nettype wire
